// file: pcg_top.sv
// Purpose: peripheral clock gates, serial clock dividers and the
//          watchdog clock source select behind an AHB-Lite slave
// Assumes: single whole-word transfers, one clock, zero wait states
// Notes:   gates and divided clocks leave as clock-enable levels and
//          pulses, so every change lands on an hclk edge
//          the commit bit is a plain read-write bit
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/10ps

module pcg_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave port
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // peripheral clock gates, high passes the clock
  output logic             flash_array_clock_gate,
  output logic             i2c_clock_gate,
  output logic             gpio_clock_gate,
  output logic             short_timer0_clock_gate,
  output logic             short_timer1_clock_gate,
  output logic             long_timer0_clock_gate,
  output logic             long_timer1_clock_gate,
  output logic             serial_port0_clock_gate,
  output logic             uart_clock_gate,
  output logic             adc_clock_gate,
  output logic             watchdog_clock_gate,
  output logic             pin_config_block_clock_gate,
  output logic             can_clock_gate,
  output logic             serial_port1_clock_gate,
  // divided peripheral clocks as enable pulses
  output logic             serial0_peripheral_clock,
  output logic             uart_peripheral_clock,
  output logic             serial1_peripheral_clock,
  // applied watchdog clock source
  output logic [1:0]       watchdog_source_active,
  output logic             watchdog_source_changed
);

  // every flip-flop of this module lives in one struct, so
  // the whole next state is built in one combinational
  // process and loaded in one clocked process, which keeps
  // the reset values of all fields in one place
  // all software-visible and bus state of this module
  typedef struct packed {
    logic [31:0] gate;     // gate register, writable bits only
    logic [7:0]  div0;     // first serial divider
    logic [7:0]  divu;     // UART divider
    logic [7:0]  div1;     // second serial divider
    logic [1:0]  wsel;     // written watchdog source
    logic        wuen;     // commit bit
    logic        wr_pend;  // write data phase in progress
    logic [31:0] wr_addr;  // address of pending write
    logic [31:0] rdata;    // read data for the data phase
    logic        ready;    // hreadyout
    logic        resp;     // hresp
  } pcg_regs_t;

  // state, its next value and two bus helpers
  pcg_regs_t   st_r;       // registered state
  pcg_regs_t   st_nxt;     // next state
  logic        take;       // transfer taken this cycle
  logic [31:0] rd_word;    // word selected for reading

  // htrans bit 1 covers both NONSEQ and SEQ, and hready
  // keeps us from taking an address phase while another
  // slave stretches its data phase; idle and busy
  // transfers are ignored but still see OKAY and no wait
  // a transfer is taken on a valid address phase
  assign take = hsel && hready && htrans[1];

  // write: the address phase is taken at one edge and held
  // in wr_addr; hwdata arrives in the next cycle and lands in
  // the register at the edge that ends that data phase
  // read: the word is picked at the edge that takes the
  // address phase, so hrdata stands through the data phase
  // and drops back to zero afterwards
  // back-to-back transfers need no wait state either way
  // register file and bus sequencing
  always_comb
  begin
    // defaults: idle answer, no write pending
    st_nxt         = st_r;
    rd_word        = 32'h00000000;
    st_nxt.ready   = 1'b1;
    st_nxt.resp    = pcg_pkg::RESP_OKAY;
    st_nxt.wr_pend = 1'b0;
    // only the writable field of each word is kept; the
    // upper bits of divider and select words are dropped
    // data phase of a write: store hwdata
    if (st_r.wr_pend)
    begin
      unique case (st_r.wr_addr[31:2])
        pcg_pkg::ADDR_GATE[31:2]:
        begin
          st_nxt.gate = hwdata & pcg_pkg::GATE_MASK;
        end
        pcg_pkg::ADDR_DIV0[31:2]:
        begin
          st_nxt.div0 = hwdata[7:0];
        end
        pcg_pkg::ADDR_DIVU[31:2]:
        begin
          st_nxt.divu = hwdata[7:0];
        end
        pcg_pkg::ADDR_DIV1[31:2]:
        begin
          st_nxt.div1 = hwdata[7:0];
        end
        pcg_pkg::ADDR_WSEL[31:2]:
        begin
          // applied later, only by a commit step
          // source code stored only
          st_nxt.wsel = hwdata[1:0];
        end
        pcg_pkg::ADDR_WUEN[31:2]:
        begin
          // zero then one here commits the source
          // single commit bit
          st_nxt.wuen = hwdata[0];
        end
        default:
        begin
          // the bus still sees OKAY and no wait
          // unmapped write is dropped
          st_nxt.wuen = st_nxt.wuen;
        end
      endcase
    end
    // a write taken here overlaps the data phase of an
    // earlier write, which was stored just above
    // address phase: latch writes, prepare reads
    if (take && hwrite)
    begin
      st_nxt.wr_pend = 1'b1;
      st_nxt.wr_addr = haddr;
    end
    // read mux looks at the updated copy, so a
    // read right after a write sees the new value
    // the mux decodes the live address phase
    unique case (haddr[31:2])
      pcg_pkg::ADDR_GATE[31:2]:
      begin
        rd_word = st_nxt.gate & pcg_pkg::GATE_MASK;
      end
      pcg_pkg::ADDR_DIV0[31:2]:
      begin
        // first serial divisor, upper bits zero
        rd_word = {24'h000000, st_nxt.div0};
      end
      pcg_pkg::ADDR_DIVU[31:2]:
      begin
        // UART divisor, upper bits zero
        rd_word = {24'h000000, st_nxt.divu};
      end
      pcg_pkg::ADDR_DIV1[31:2]:
      begin
        // second serial divisor, upper bits zero
        rd_word = {24'h000000, st_nxt.div1};
      end
      pcg_pkg::ADDR_WSEL[31:2]:
      begin
        // written code, not the applied one
        rd_word = {30'h00000000, st_nxt.wsel};
      end
      pcg_pkg::ADDR_WUEN[31:2]:
      begin
        // commit bit as last written
        rd_word = {31'h00000000, st_nxt.wuen};
      end
      default:
      begin
        // unmapped address reads zero
        rd_word = 32'h00000000;
      end
    endcase
    // zero outside a read data phase, so a stale word
    // never lingers on the shared read bus
    // read data valid through the data phase
    if (take && !hwrite)
      st_nxt.rdata = rd_word;
    else
      st_nxt.rdata = 32'h00000000;
  end

  // asynchronous reset loads constants only; every
  // field is named so that reset values stay visible
  // state register, reset values of every field
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // first serial gate on at reset
      st_r.gate    <= pcg_pkg::GATE_RST;
      st_r.div0    <= pcg_pkg::DIV_RST;
      st_r.divu    <= pcg_pkg::DIV_RST;
      st_r.div1    <= pcg_pkg::DIV_RST;
      st_r.wsel    <= pcg_pkg::WSEL_RST;
      st_r.wuen    <= pcg_pkg::WUEN_RST;
      // no transfer in flight after reset
      st_r.wr_pend <= 1'b0;
      st_r.wr_addr <= 32'h00000000;
      st_r.rdata   <= 32'h00000000;
      st_r.ready   <= 1'b1;
      st_r.resp    <= pcg_pkg::RESP_OKAY;
    end
    else
    begin
      // load the next state built above
      st_r <= st_nxt;
    end
  end

  // the slave never inserts wait states and never errors,
  // so ready and response are constant flip-flops; they
  // still come from registers to keep outputs glitch free
  // bus answer straight from the registers
  assign hreadyout = st_r.ready;
  assign hresp     = st_r.resp;
  assign hrdata    = st_r.rdata;

  // gate levels drive clock-gate cells outside this block;
  // bits 3:0 and 14 have no output here
  // gate outputs are register bits, so they switch
  // only on an hclk edge and cannot cut a pulse short
  // edge-aligned gate levels
  assign flash_array_clock_gate  = st_r.gate[pcg_pkg::BIT_FLASH];
  assign i2c_clock_gate          = st_r.gate[pcg_pkg::BIT_I2C];
  assign gpio_clock_gate         = st_r.gate[pcg_pkg::BIT_GPIO];
  // short timers on bits 7 and 8, long ones on 9 and 10
  // four timer gates
  assign short_timer0_clock_gate = st_r.gate[pcg_pkg::BIT_ST0];
  assign short_timer1_clock_gate = st_r.gate[pcg_pkg::BIT_ST1];
  assign long_timer0_clock_gate  = st_r.gate[pcg_pkg::BIT_LT0];
  assign long_timer1_clock_gate  = st_r.gate[pcg_pkg::BIT_LT1];
  assign serial_port0_clock_gate = st_r.gate[pcg_pkg::BIT_SER0];
  assign uart_clock_gate         = st_r.gate[pcg_pkg::BIT_UART];
  assign adc_clock_gate          = st_r.gate[pcg_pkg::BIT_ADC];
  assign watchdog_clock_gate     = st_r.gate[pcg_pkg::BIT_WDT];
  assign pin_config_block_clock_gate = st_r.gate[pcg_pkg::BIT_PCFG];
  assign can_clock_gate          = st_r.gate[pcg_pkg::BIT_CAN];
  assign serial_port1_clock_gate = st_r.gate[pcg_pkg::BIT_SER1];

  // each divided clock is a one-cycle enable pulse every n
  // hclk cycles; a new divisor waits for the running period
  // to end, so no period is ever cut short
  // a divisor of one keeps the enable high all the time
  // whole periods only
  pcg_clk_div #(
    .W         (pcg_pkg::DIV_W)
  ) u_div0 (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .div_value (st_r.div0),
    .clk_pulse (serial0_peripheral_clock)
  );

  // UART enable pulse for the baud logic
  // UART clock divider
  pcg_clk_div #(
    .W         (pcg_pkg::DIV_W)
  ) u_divu (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .div_value (st_r.divu),
    .clk_pulse (uart_peripheral_clock)
  );

  // second serial port enable pulse
  // second serial clock divider
  pcg_clk_div #(
    .W         (pcg_pkg::DIV_W)
  ) u_div1 (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .div_value (st_r.div1),
    .clk_pulse (serial1_peripheral_clock)
  );

  // the written code sits in wsel until software steps the
  // commit bit from zero to one; the applied code and a
  // one-cycle change pulse come out of flip-flops one
  // edge after the write data phase ends
  // a reserved code is refused inside the commit module
  // and the source in use stays as it was
  // commit on rising edge of commit bit
  pcg_src_commit u_commit (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .sel_written (st_r.wsel),
    .commit_bit  (st_r.wuen),
    .sel_active  (watchdog_source_active),
    .sel_changed (watchdog_source_changed)
  );

  // hsize is accepted unchecked: only whole words are used
  // and narrower accesses are treated as whole words,
  // so a narrow write stores the whole hwdata word
endmodule // pcg_top

// file: pcg_pkg.sv
// Purpose: shared constants of the peripheral clock gating block
// Assumes: 32-bit AHB-Lite register access, whole words only
// Notes:   addresses are full byte addresses of each register
package pcg_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_GATE = 32'h40048080;
  localparam logic [31:0] ADDR_DIV0 = 32'h40048094;
  localparam logic [31:0] ADDR_DIVU = 32'h40048098;
  localparam logic [31:0] ADDR_DIV1 = 32'h4004809C;
  localparam logic [31:0] ADDR_WSEL = 32'h400480D0;
  localparam logic [31:0] ADDR_WUEN = 32'h400480D4;
  // gate register bit positions
  localparam int BIT_FLASH = 4;
  localparam int BIT_I2C   = 5;
  localparam int BIT_GPIO  = 6;
  localparam int BIT_ST0   = 7;
  localparam int BIT_ST1   = 8;
  localparam int BIT_LT0   = 9;
  localparam int BIT_LT1   = 10;
  localparam int BIT_SER0  = 11;
  localparam int BIT_UART  = 12;
  localparam int BIT_ADC   = 13;
  localparam int BIT_WDT   = 15;
  localparam int BIT_PCFG  = 16;
  localparam int BIT_CAN   = 17;
  localparam int BIT_SER1  = 18;
  // gate register reset value and writable bits
  localparam logic [31:0] GATE_RST  = 32'h00000850;
  localparam logic [31:0] GATE_MASK = 32'h0007BFF0;
  // divider and select fields
  localparam int          DIV_W    = 8;
  localparam logic [7:0]  DIV_RST  = 8'h00;
  localparam int          WSEL_W   = 2;
  localparam logic [1:0]  WSEL_RST = 2'h0;
  localparam logic        WUEN_RST = 1'b0;
  // watchdog clock source codes
  localparam logic [1:0]  SRC_RC_OSC = 2'h0;
  localparam logic [1:0]  SRC_MAIN = 2'h1;
  localparam logic [1:0]  SRC_WOSC = 2'h2;
  localparam logic [1:0]  SRC_RSVD = 2'h3;
  // bus answer codes
  localparam logic        RESP_OKAY = 1'b0;
endpackage

// file: pcg_clk_div.sv
// Purpose: divides hclk into a one-cycle clock enable every n cycles
// Assumes: divisor comes from a register on the same clock
// Notes:   a new divisor is taken at a period boundary, or at once while stopped
`timescale 1ns/10ps
module pcg_clk_div #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // divisor in, 0 stops the output
  input  wire logic [W-1:0] div_value,
  // divided clock as a clock-enable pulse
  output logic              clk_pulse
);
  typedef struct packed {
    logic [W-1:0] cnt;   // cycles into the period
    logic [W-1:0] cur;   // divisor of the running period
    logic         pulse; // registered output
  } pcg_div_t;
  pcg_div_t st_r;
  pcg_div_t st_nxt;

  // period counter, divisor reloaded at period end or while stopped
  always_comb
  begin
    st_nxt = st_r;
    if (st_r.cur == '0)
    begin
      // stopped: wait for a nonzero divisor
      st_nxt.pulse = 1'b0;
      st_nxt.cnt   = '0;
      st_nxt.cur   = div_value;
    end
    else if (st_r.cnt >= st_r.cur - W'(1))
    begin
      // period complete: one pulse, pick up divisor
      st_nxt.pulse = 1'b1;
      st_nxt.cnt   = '0;
      st_nxt.cur   = div_value;
    end
    else
    begin
      st_nxt.pulse = 1'b0;
      st_nxt.cnt   = st_r.cnt + W'(1);
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign clk_pulse = st_r.pulse;
endmodule // pcg_clk_div

// file: pcg_src_commit.sv
// Purpose: holds the applied watchdog clock source
// Assumes: select and commit bit come from registers on hclk
// Notes:   reserved source code is never applied
`timescale 1ns/10ps
module pcg_src_commit (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // software side
  input  wire logic [1:0] sel_written,
  input  wire logic       commit_bit,
  // applied source and one-cycle change pulse
  output logic [1:0]      sel_active,
  output logic            sel_changed
);
  typedef struct packed {
    logic [1:0] act;  // applied source
    logic       prev; // commit bit one cycle ago
    logic       chg;  // change pulse
  } pcg_cmt_t;
  pcg_cmt_t st_r;
  pcg_cmt_t st_nxt;

  // apply on a low-to-high step of the commit bit only
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.prev = commit_bit;
    st_nxt.chg  = 1'b0;
    if (commit_bit && !st_r.prev && sel_written != pcg_pkg::SRC_RSVD)
    begin
      st_nxt.act = sel_written;
      st_nxt.chg = 1'b1;
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '{act: pcg_pkg::WSEL_RST, prev: pcg_pkg::WUEN_RST, chg: 1'b0};
    else
      st_r <= st_nxt;
  end

  assign sel_active  = st_r.act;
  assign sel_changed = st_r.chg;
endmodule // pcg_src_commit

// file: pcg_asserts.sv
// Purpose: bus and output relations of the clock gating block
// Assumes: bound to pcg_top, one clock domain
// Notes:   watches only the ports it names
`timescale 1ns/10ps
module pcg_asserts (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus side
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // outputs watched
  input wire logic        flash_array_clock_gate,
  input wire logic        gpio_clock_gate,
  input wire logic [1:0]  watchdog_source_active,
  input wire logic        watchdog_source_changed
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // transfer taken at this edge
  wire tk = hsel && hready && htrans[1];
  // address hits one of the mapped words
  wire hit = haddr == pcg_pkg::ADDR_GATE || haddr == pcg_pkg::ADDR_DIV0
    || haddr == pcg_pkg::ADDR_DIVU || haddr == pcg_pkg::ADDR_DIV1
    || haddr == pcg_pkg::ADDR_WSEL || haddr == pcg_pkg::ADDR_WUEN;
  // gate write address phase then its data phase
  sequence s_gate_wr;
    tk && hwrite && haddr == pcg_pkg::ADDR_GATE ##1 1'h1;
  endsequence
  property p_okay;
    hreadyout && hresp == pcg_pkg::RESP_OKAY;
  endproperty
  property p_idle;
    !(tk && !hwrite) |=> hrdata == 32'h0;
  endproperty
  property p_unmap;
    tk && !hwrite && !hit |=> hrdata == 32'h0;
  endproperty
  property p_flash;
    s_gate_wr |=> flash_array_clock_gate == $past(hwdata[4]);
  endproperty
  property p_gpio;
    s_gate_wr |=> gpio_clock_gate == $past(hwdata[6]);
  endproperty
  property p_rst;
    $rose(hresetn) |-> flash_array_clock_gate && gpio_clock_gate;
  endproperty
  property p_chg;
    $changed(watchdog_source_active) |-> watchdog_source_changed;
  endproperty
  property p_pulse;
    watchdog_source_changed |=> !watchdog_source_changed;
  endproperty
  property p_rsvd;
    watchdog_source_active != pcg_pkg::SRC_RSVD;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or okay");
  a_idle: assert property (p_idle) else $error("read data not cleared");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_flash: assert property (p_flash) else $error("flash gate");
  a_gpio: assert property (p_gpio) else $error("gpio gate");
  a_rst: assert property (p_rst) else $error("gate reset value");
  a_chg: assert property (p_chg) else $error("source moved");
  a_pulse: assert property (p_pulse) else $error("long pulse");
  a_rsvd: assert property (p_rsvd) else $error("reserved source");
endmodule // pcg_asserts

bind pcg_top pcg_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
  .flash_array_clock_gate, .gpio_clock_gate, .watchdog_source_active,
  .watchdog_source_changed);

// file: tb_peripheral_clock_gating_and_dividers.sv
// Purpose: self-checking bench of the clock gating block
// Assumes: zero wait-state slave, hready fed from hreadyout
// Notes:   gates compared as a vector in bit order 4-13, 15-18
`timescale 1ns/10ps
module tb_peripheral_clock_gating_and_dividers;
  logic        hclk, hresetn, hsel, hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic        hreadyout, hresp, watchdog_source_changed;
  logic [1:0]  watchdog_source_active;
  logic [13:0] gv;
  logic [2:0]  pclk;
  wire         hready = hreadyout;
  int          n_mismatch = 0, checks_done = 0, cyc = 0;
  logic [31:0] da [3];
  // device under test
  pcg_top u_dut (.*,
    .flash_array_clock_gate(gv[0]), .i2c_clock_gate(gv[1]),
    .gpio_clock_gate(gv[2]), .short_timer0_clock_gate(gv[3]),
    .short_timer1_clock_gate(gv[4]), .long_timer0_clock_gate(gv[5]),
    .long_timer1_clock_gate(gv[6]), .serial_port0_clock_gate(gv[7]),
    .uart_clock_gate(gv[8]), .adc_clock_gate(gv[9]),
    .watchdog_clock_gate(gv[10]), .pin_config_block_clock_gate(gv[11]),
    .can_clock_gate(gv[12]), .serial_port1_clock_gate(gv[13]),
    .serial0_peripheral_clock(pclk[0]), .uart_peripheral_clock(pclk[1]),
    .serial1_peripheral_clock(pclk[2]));
  // clock
  initial
  begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      conclude;
    end
  end
  // compare and count
  task chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // one single AHB transfer, read data taken at the data phase edge
  task xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    q = hrdata;
  endtask
  // expected gate outputs from a register word
  function automatic logic [13:0] gx(input logic [31:0] r);
    return {r[18:15], r[13:4]};
  endfunction
  // reset values of every register and of the gate outputs
  task t_reset;
    xfer(1'h0, pcg_pkg::ADDR_GATE, 32'h0, v);
    chk("gate rst", pcg_pkg::GATE_RST, v);
    chk("gates rst", 32'(gx(pcg_pkg::GATE_RST)), 32'(gv));
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'h0, da[i], 32'h0, v);
      chk("div rst", 32'h0, v);
    end
    xfer(1'h0, pcg_pkg::ADDR_WSEL, 32'h0, v);
    chk("sel rst", 32'h0, v);
    xfer(1'h0, pcg_pkg::ADDR_WUEN, 32'h0, v);
    chk("commit rst", 32'h0, v);
    xfer(1'h1, pcg_pkg::ADDR_WUEN, 32'hFFFFFFFF, v);
    xfer(1'h0, pcg_pkg::ADDR_WUEN, 32'h0, v);
    chk("commit bits", 32'h1, v);
    xfer(1'h1, pcg_pkg::ADDR_WUEN, 32'h0, v);
    xfer(1'h1, 32'h400480A0, 32'hFFFFFFFF, v);
    xfer(1'h0, 32'h400480A0, 32'h0, v);
    chk("unmapped", 32'h0, v);
  endtask
  // gate patterns, reserved bits must read zero
  task t_gate;
    logic [31:0] p [4];
    // pin config clock on before the UART clock
    p = '{32'h00010000, 32'hFFFFFFFF, 32'h00000000, 32'h0003A5A0};
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'h1, pcg_pkg::ADDR_GATE, p[i], v);
      xfer(1'h0, pcg_pkg::ADDR_GATE, 32'h0, v);
      chk("gate rd", p[i] & pcg_pkg::GATE_MASK, v);
      chk("gates", 32'(gx(p[i])), 32'(gv));
    end
  endtask
  // stop then divide by n on each divided clock
  task t_div;
    logic [7:0] n [3];
    int k;
    n = '{8'h02, 8'h01, 8'hFF};
    for (int i = 0; i < 3; i++)
      for (int j = 0; j < 3; j++)
      begin
        xfer(1'h1, da[i], 32'h0, v);
        repeat (260) @(posedge hclk);
        k = 0;
        repeat (8) @(posedge hclk) k += pclk[i];
        chk("stopped", 32'h0, 32'(k));
        xfer(1'h1, da[i], {24'hFFFFFF, n[j]}, v);
        xfer(1'h0, da[i], 32'h0, v);
        chk("div rd", {24'h0, n[j]}, v);
        k = 0;
        while (pclk[i] !== 1'h1 && k < 600)
        begin
          @(posedge hclk);
          k++;
        end
        k = 0;
        do
        begin
          @(posedge hclk);
          k++;
        end
        while (pclk[i] !== 1'h1 && k < 600);
        chk("period", 32'(n[j]), 32'(k));
      end
  endtask
  // source codes applied only by a commit rising edge
  task t_wdt;
    logic [1:0] sc [4], ex [4], pr;
    int c;
    sc = '{pcg_pkg::SRC_WOSC, pcg_pkg::SRC_MAIN, pcg_pkg::SRC_RSVD,
      pcg_pkg::SRC_RC_OSC};
    ex = '{pcg_pkg::SRC_WOSC, pcg_pkg::SRC_MAIN, pcg_pkg::SRC_MAIN,
      pcg_pkg::SRC_RC_OSC};
    pr = 2'h0;
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'h1, pcg_pkg::ADDR_WSEL, 32'(sc[k]), v);
      if (k > 0)
        xfer(1'h1, pcg_pkg::ADDR_WUEN, 32'h1, v);
      repeat (4) @(posedge hclk);
      chk("held", 32'(pr), 32'(watchdog_source_active));
      // software commit toggle low then high
      xfer(1'h1, pcg_pkg::ADDR_WUEN, 32'h0, v);
      xfer(1'h1, pcg_pkg::ADDR_WUEN, 32'h1, v);
      c = 0;
      repeat (6) @(posedge hclk) c += watchdog_source_changed;
      chk("pulses", 32'(ex[k] != pr), 32'(c));
      chk("active", 32'(ex[k]), 32'(watchdog_source_active));
      xfer(1'h0, pcg_pkg::ADDR_WSEL, 32'h0, v);
      chk("sel rd", 32'(sc[k]), v);
      pr = ex[k];
    end
  endtask
  // verdict
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    da = '{pcg_pkg::ADDR_DIV0, pcg_pkg::ADDR_DIVU, pcg_pkg::ADDR_DIV1};
    hresetn = 1'h0;
    hsel = 1'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset;
    t_gate;
    t_div;
    t_wdt;
    conclude;
  end
endmodule // tb_peripheral_clock_gating_and_dividers
